// ---- console_model.sv ----
`timescale 1ns/1ps
`include "fault_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// handheld console: an axi4-lite master that presses keys and reads the display
module console_model (
  // clock
  input wire logic clk_in,
  // axi4-lite master
  output logic awvalid_out,
  input wire logic awready_in,
  output fault_pkg::addr_t awaddr_out,
  output logic wvalid_out,
  input wire logic wready_in,
  output fault_pkg::word_t wdata_out,
  output logic [3:0] wstrb_out,
  input wire logic bvalid_in,
  output logic bready_out,
  input wire logic [1:0] bresp_in,
  output logic arvalid_out,
  input wire logic arready_in,
  output fault_pkg::addr_t araddr_out,
  input wire logic rvalid_in,
  output logic rready_out,
  input wire fault_pkg::word_t rdata_in,
  input wire logic [1:0] rresp_in
);
  import fault_pkg::*;
  logic console_link_fault_message = 1'b0; // link fault on display: keypad locked
  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, araddr_out} = 16'h0000;
    wdata_out = 32'h00000000;
    wstrb_out = 4'h0;
  end
  // one write; released payload is inverted so stale values never look valid
  task automatic wr(input addr_t a, input word_t d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_in);
    awvalid_out <= 1'b1;
    awaddr_out <= a;
    wvalid_out <= 1'b1;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    bready_out <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      // each channel released at its own handshake
      if (awvalid_out && awready_in) begin
        aw_done = 1'b1;
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        w_done = 1'b1;
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end
    do @(posedge clk_in); while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask : wr
  // one read
  task automatic rd(input addr_t a, output word_t d, output logic [1:0] r);
    @(posedge clk_in);
    arvalid_out <= 1'b1;
    araddr_out <= a;
    rready_out <= 1'b1;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    do @(posedge clk_in); while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask : rd
  // monitor or clear key; once locked only clear goes through
  task automatic press(input logic run, input logic mon);
    logic [1:0] r;
    if (console_link_fault_message && mon) return;
    if (!mon) console_link_fault_message = 1'b0;
    wr(`REG_CTRL, {29'h0, mon, ~mon, run}, r);
  endtask : press
  // read the shown message; a link fault locks the keypad
  task automatic show(output code_t c);
    word_t d;
    logic [1:0] r;
    rd(`REG_MESSAGE, d, r);
    c = d[3:0];
    if (c == `MSG_LINK_FAULT) console_link_fault_message = 1'b1;
  endtask : show
endmodule : console_model

// ---- controller_fault_reporting.sv ----
// Function
// - fatal faults: error light, halt, outputs off
// - non-fatal link fault keeps program running; non-fatal power fault halts it
// - separate power, error and link indicators
// - each monitor press shows next message
// - monitor read in program mode removes message
// - clearing allowed while in run mode
// - list empty: all-clear shown, error light off
// - watchdog expiry is fatal and halts
// - fatal error halts controller and program
// - missing terminator is fatal, run refused
// - corrupt program image raises memory fault
// - link fault turns link light off
// - last location not no-op: program overflow
// - address beyond last location: address overflow
// - operand outside range: operand error
// - entry errors only in program mode
`timescale 1ns/1ps
`include "fault_defs.svh"

module controller_fault_reporting #(
  parameter int unsigned WDOG_CYCLES = `WDOG_TIME_MS * `CLK_MHZ * 1000
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // axi4-lite slave
  input wire logic awvalid_in,
  output logic awready_out,
  input wire fault_pkg::addr_t awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire fault_pkg::word_t wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire fault_pkg::addr_t araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output fault_pkg::word_t rdata_out,
  output logic [1:0] rresp_out,
  // pins from outside
  input wire logic power_fault_in,
  input wire logic link_fault_in,
  // cpu core side
  input wire logic mem_fault_in,
  input wire logic wdog_kick_in,
  input wire logic end_found_in,
  input wire logic last_loc_nop_in,
  // program store write port
  output logic prog_wr_out,
  output logic [9:0] prog_addr_out,
  output logic [15:0] prog_word_out,
  // indicators and control
  output logic power_led_out,
  output logic run_led_out,
  output logic error_led_out,
  output logic link_led_out,
  output logic outputs_on_out,
  output logic irq_out
);
  import fault_pkg::*;

  state_t q;
  state_t d;
  logic wr_go; // write address and data both held
  logic rd_go; // read address taken
  logic mon_press; // monitor key pulse
  logic clr_press; // clear key pulse
  logic run_wr; // run bit written
  logic entry_wr; // entry register written
  logic push; // a message goes into the store
  logic pop; // head message removed
  code_t push_code; // message being stored
  logic [`IRQ_BITS-1:0] irq_ev; // events for status bits
  logic link_rise; // new link fault
  logic wdog_expire; // watchdog ran out
  logic [9:0] e_addr; // entry address field
  logic [15:0] e_opnd; // entry operand field
  word_t wmask; // enabled byte lanes of the held write

  //////////////////////////////////////////////////////////////////////////
  // helpers
  // true for an offset that holds a register
  function automatic logic is_mapped(input addr_t a);
    return a == `REG_CTRL || a == `REG_STATUS || a == `REG_MESSAGE ||
      a == `REG_ENTRY || a == `REG_ENTRY_RESULT || a == `REG_IRQ_STATUS ||
      a == `REG_IRQ_MASK;
  endfunction : is_mapped

  // byte lanes of a write that are enabled
  function automatic word_t lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    // pins pass two flops before use
    d.pwr_s1 = power_fault_in;
    d.pwr_s2 = q.pwr_s1;
    d.link_s1 = link_fault_in;
    d.link_s2 = q.link_s1;
    d.link_s3 = q.link_s2;
    link_rise = q.link_s2 && !q.link_s3;
    // bus handshakes
    if (q.bvalid && bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && rready_in) begin
      d.rvalid = 1'b0;
    end
    if (awvalid_in && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr_in;
    end
    if (wvalid_in && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = wdata_in;
      d.w_strb = wstrb_in;
    end
    wr_go = q.aw_full && q.w_full && !q.bvalid;
    rd_go = arvalid_in && q.arready;
    run_wr = wr_go && q.aw_addr == `REG_CTRL && q.w_strb[0];
    mon_press = run_wr && q.w_data[`CTRL_MONITOR_KEY];
    clr_press = run_wr && q.w_data[`CTRL_CLEAR_KEY];
    entry_wr = wr_go && q.aw_addr == `REG_ENTRY;
    e_addr = q.w_data[`ENTRY_ADDR_MSB:`ENTRY_ADDR_LSB];
    e_opnd = q.w_data[`ENTRY_OPND_MSB:`ENTRY_OPND_LSB];
    wmask = lane_mask(q.w_strb);
    irq_ev = '0;
    push = 1'b0;
    pop = 1'b0;
    push_code = `MSG_NONE;
    wdog_expire = 1'b0;
    d.prog_wr = 1'b0;
    // write response after both halves arrived
    if (wr_go) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      if (q.aw_addr == `REG_IRQ_MASK) begin
        d.irq_mask = (q.irq_mask & ~wmask[`IRQ_BITS-1:0]) |
          (q.w_data[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0]);
      end
    end
    // watchdog runs while the program runs
    if (q.mode == MODE_RUN) begin
      if (wdog_kick_in) begin
        d.wdog_cnt = '0;
      end else if (q.wdog_cnt == WDOG_CYCLES - 1) begin
        wdog_expire = 1'b1;
      end else begin
        d.wdog_cnt = q.wdog_cnt + 32'h1;
      end
    end else begin
      d.wdog_cnt = '0;
    end
    // fault sources, first one wins the store slot
    if (mem_fault_in) begin
      push = 1'b1;
      push_code = `MSG_MEMORY;
    end else if (wdog_expire) begin
      push = 1'b1;
      push_code = `MSG_WATCHDOG;
    end else if (run_wr && q.w_data[`CTRL_RUN] && !end_found_in) begin
      push = 1'b1;
      push_code = `MSG_MISSING_TERM;
    end else if (link_rise) begin
      push = 1'b1;
      push_code = `MSG_LINK_FAULT;
    end
    // mode changes
    if (run_wr) begin
      if (!q.w_data[`CTRL_RUN]) begin
        d.mode = MODE_PROGRAM;
      end else if (!q.fatal && end_found_in && !q.pwr_s2) begin
        d.mode = MODE_RUN;
      end
    end
    if (mem_fault_in || wdog_expire || q.pwr_s2 ||
        (run_wr && q.w_data[`CTRL_RUN] && !end_found_in)) begin
      d.mode = MODE_PROGRAM;
    end
    if (push && push_code != `MSG_LINK_FAULT) begin
      d.fatal = 1'b1;
      irq_ev[`IRQ_FATAL] = 1'b1;
    end
    // link fault is not fatal, cleared by the clear key
    if (clr_press) begin
      d.link_fault = 1'b0;
    end
    if (link_rise) begin
      d.link_fault = 1'b1;
      irq_ev[`IRQ_LINK] = 1'b1;
    end
    // program entry checks
    if (entry_wr) begin
      if (q.mode == MODE_RUN) begin
        d.entry_result = `ENTRY_REFUSED;
      end else if (e_addr > `PROG_LAST_ADDR) begin
        d.entry_result = `ENTRY_ADDR_OVER;
      end else if (!last_loc_nop_in) begin
        d.entry_result = `ENTRY_PROG_OVER;
      end else if (e_opnd > `OPERAND_MAX) begin
        d.entry_result = `ENTRY_OPND_ERR;
      end else begin
        d.entry_result = `ENTRY_OK;
        d.prog_wr = 1'b1;
        d.prog_addr = e_addr;
        d.prog_word = e_opnd;
      end
      if (q.mode == MODE_PROGRAM && !(e_addr <= `PROG_LAST_ADDR && last_loc_nop_in &&
          e_opnd <= `OPERAND_MAX)) begin
        irq_ev[`IRQ_ENTRY_ERR] = 1'b1;
      end
    end
    // monitor key reads the store
    if (mon_press) begin
      if (q.count == '0) begin
        d.message = `MSG_ALL_CLEAR;
      end else if (q.mode == MODE_RUN) begin
        d.message = q.mem[q.rd_ptr + q.peek];
        d.peek = (q.peek == `MSG_PTR_W'(q.count - 1'b1)) ? '0 : q.peek + 1'b1;
      end else begin
        d.message = q.mem[q.rd_ptr];
        pop = 1'b1;
        d.peek = '0;
      end
    end
    // message store, first in first out
    if (push && q.count != `MSG_CNT_W'(`MSG_DEPTH)) begin
      d.mem[q.wr_ptr] = push_code;
      d.wr_ptr = q.wr_ptr + 1'b1;
      irq_ev[`IRQ_MSG] = 1'b1;
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    d.count = q.count + `MSG_CNT_W'(irq_ev[`IRQ_MSG]) - `MSG_CNT_W'(pop);
    if (pop && d.count == '0 && !irq_ev[`IRQ_FATAL]) begin
      d.fatal = 1'b0; // last message stays shown
    end
    // sticky status, event wins over clear
    d.irq_stat = q.irq_stat | irq_ev;
    if (wr_go && q.aw_addr == `REG_IRQ_STATUS) begin
      d.irq_stat = (q.irq_stat & ~(q.w_data[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0])) | irq_ev;
    end
    d.irq = |(d.irq_stat & d.irq_mask);
    // read data
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = is_mapped(araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (araddr_in)
        `REG_CTRL: d.rdata = {31'h0, q.mode == MODE_RUN};
        `REG_STATUS: d.rdata = {24'h0, q.count, q.pwr_s2, q.link_fault, q.fatal,
          q.mode == MODE_RUN};
        `REG_MESSAGE: d.rdata = {28'h0, q.message};
        `REG_ENTRY: d.rdata = {6'h0, q.prog_addr, q.prog_word};
        `REG_ENTRY_RESULT: d.rdata = {28'h0, q.entry_result};
        `REG_IRQ_STATUS: d.rdata = {28'h0, q.irq_stat};
        `REG_IRQ_MASK: d.rdata = {28'h0, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end
    // handshake readies for the next cycle
    d.awready = !d.aw_full && !d.bvalid;
    d.wready = !d.w_full && !d.bvalid;
    d.arready = !d.rvalid;
    // indicators
    d.outputs_on = d.mode == MODE_RUN && !d.fatal && !d.pwr_s2;
    d.power_led = !d.pwr_s2;
    d.run_led = d.mode == MODE_RUN;
    d.error_led = d.fatal;
    d.link_led = !d.link_fault;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.mode <= MODE_PROGRAM;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign awready_out = q.awready;
  assign wready_out = q.wready;
  assign bvalid_out = q.bvalid;
  assign bresp_out = q.bresp;
  assign arready_out = q.arready;
  assign rvalid_out = q.rvalid;
  assign rdata_out = q.rdata;
  assign rresp_out = q.rresp;
  assign prog_wr_out = q.prog_wr;
  assign prog_addr_out = q.prog_addr;
  assign prog_word_out = q.prog_word;
  assign power_led_out = q.power_led;
  assign run_led_out = q.run_led;
  assign error_led_out = q.error_led;
  assign link_led_out = q.link_led;
  assign outputs_on_out = q.outputs_on;
  assign irq_out = q.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks
  // memory fault halts and lights the error indicator
  property p_mem_halt;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      mem_fault_in |=> (q.fatal && q.mode == MODE_PROGRAM) ##1 (error_led_out && !outputs_on_out);
  endproperty
  a_mem_halt: assert property (p_mem_halt) else $error("memory fault did not halt");
  // link fault alone leaves the run going
  property p_link_nonfatal;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (link_rise && push_code == `MSG_LINK_FAULT && q.mode == MODE_RUN && !run_wr &&
       !q.pwr_s2) |=> q.mode == MODE_RUN;
  endproperty
  a_link_nonfatal: assert property (p_link_nonfatal) else $error("link fault stopped run");
  // link indicator dark two cycles after a new fault
  property p_link_led;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      link_rise && !clr_press |=> ##1 !link_led_out;
  endproperty
  a_link_led: assert property (p_link_led) else $error("link light stayed on");
  // run mode never removes a stored message
  property p_run_keeps;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (q.mode == MODE_RUN && mon_press && !push) |=> q.count == $past(q.count);
  endproperty
  a_run_keeps: assert property (p_run_keeps) else $error("message cleared in run");
  // program mode read removes one message
  property p_prog_pops;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (q.mode == MODE_PROGRAM && mon_press && q.count != '0 && !push) |=>
        q.count == $past(q.count) - 1'b1;
  endproperty
  a_prog_pops: assert property (p_prog_pops) else $error("program read kept message");
  // emptying the list darkens the error light, a press on an empty list shows all-clear
  property p_all_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ((pop && q.count == 4'h1 && !push) |=> !q.fatal ##1 !error_led_out) and
      ((mon_press && q.count == 4'h0) |=> q.message == `MSG_ALL_CLEAR);
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("all-clear not reported");
  // watchdog fires at the counted limit in run mode
  property p_wdog;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (q.mode == MODE_RUN && !wdog_kick_in && q.wdog_cnt == WDOG_CYCLES - 1) |=>
        q.fatal && q.mode == MODE_PROGRAM;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not halt");
  // run request without terminator refused
  property p_no_term;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (run_wr && q.w_data[`CTRL_RUN] && !end_found_in) |=> q.mode == MODE_PROGRAM && q.fatal;
  endproperty
  a_no_term: assert property (p_no_term) else $error("ran without terminator");
  // out-of-range address rejected without a store write
  property p_addr_over;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (entry_wr && q.mode == MODE_PROGRAM && e_addr > `PROG_LAST_ADDR) |=>
        q.entry_result == `ENTRY_ADDR_OVER && !prog_wr_out;
  endproperty
  a_addr_over: assert property (p_addr_over) else $error("address overflow missed");
  // entry while running is refused
  property p_entry_run;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (entry_wr && q.mode == MODE_RUN) |=> q.entry_result == `ENTRY_REFUSED && !prog_wr_out;
  endproperty
  a_entry_run: assert property (p_entry_run) else $error("entry taken in run");
  // first stored message is the first one read
  property p_fifo;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (q.mode == MODE_PROGRAM && mon_press && q.count != '0) |=>
        q.message == $past(q.mem[q.rd_ptr]);
  endproperty
  a_fifo: assert property (p_fifo) else $error("message order broken");
  c_fatal_clear: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    error_led_out ##[1:50] !error_led_out);
  c_run: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !run_led_out ##1 run_led_out);
  c_peek: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    q.mode == MODE_RUN && mon_press && q.count > 4'h1);
  c_entry: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) prog_wr_out);

endmodule : controller_fault_reporting

// ---- controller_fault_reporting_bench.sv ----
`timescale 1ns/1ps
`include "fault_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module controller_fault_reporting_bench;
  import fault_pkg::*;
  // entry table row: address, operand, last location no-op, expected result
  typedef struct {logic [9:0] a; logic [15:0] o; logic no_operation_instruction; code_t res;} row_t;
  logic clk_sys_in, sys_rst_in, awvalid_in, awready_out, wvalid_in, wready_out;
  logic bvalid_out, bready_in, arvalid_in, arready_out, rvalid_out, rready_in;
  addr_t awaddr_in, araddr_in;
  word_t wdata_in, rdata_out, d;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out, r;
  logic power_fault_in, link_fault_in, mem_fault_in, wdog_kick_in, end_found_in;
  logic last_loc_nop_in, prog_wr_out, power_led_out, run_led_out, error_led_out;
  logic link_led_out, outputs_on_out, irq_out, kick_en;
  logic [9:0] prog_addr_out;
  logic [15:0] prog_word_out;
  code_t c;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_prog = 0;
  row_t rows [4];
  code_t seq [4];
  ////////////////////////////////////////////////////////////////////////////////
  // short watchdog so expiry fits the run
  controller_fault_reporting #(.WDOG_CYCLES(20)) u_controller_fault_reporting (.*);
  // console on the register bus
  console_model u_console (.clk_in(clk_sys_in), .awvalid_out(awvalid_in),
    .awready_in(awready_out), .awaddr_out(awaddr_in), .wvalid_out(wvalid_in),
    .wready_in(wready_out), .wdata_out(wdata_in), .wstrb_out(wstrb_in),
    .bvalid_in(bvalid_out), .bready_out(bready_in), .bresp_in(bresp_out),
    .arvalid_out(arvalid_in), .arready_in(arready_out), .araddr_out(araddr_in),
    .rvalid_in(rvalid_out), .rready_out(rready_in), .rdata_in(rdata_out),
    .rresp_in(rresp_out));
  ////////////////////////////////////////////////////////////////////////////////
  // 250 mhz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // core kicks the watchdog every cycle while enabled
  always @(posedge clk_sys_in) wdog_kick_in <= kick_en;
  // count accepted program store writes
  always @(posedge clk_sys_in) if (prog_wr_out) n_prog <= n_prog + 1;
  // hang guard
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: timeout", $time);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare one bit
  task automatic chk_b(input string m, input logic g, input logic e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_b
  // compare one word
  task automatic chk_w(input string m, input word_t g, input word_t e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_w
  // read a register and compare
  task automatic chk_reg(input addr_t a, input word_t e);
    u_console.rd(a, d, r);
    chk_w($sformatf("reg %h", a), d, e);
  endtask : chk_reg
  // wait whole cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  // counts and verdict
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    {power_fault_in, link_fault_in, mem_fault_in, kick_en} = 4'h0;
    {end_found_in, last_loc_nop_in} = 2'b11;
    rows = '{'{10'h15b, 16'h0fff, 1'b1, `ENTRY_OK}, '{10'h15c, 16'h0000, 1'b1, `ENTRY_ADDR_OVER},
      '{10'h000, 16'h0001, 1'b0, `ENTRY_PROG_OVER}, '{10'h001, 16'h1000, 1'b1, `ENTRY_OPND_ERR}};
    seq = '{`MSG_LINK_FAULT, `MSG_WATCHDOG, `MSG_MEMORY, `MSG_ALL_CLEAR};
    tick(6);
    sys_rst_in <= 1'b0;
    tick(4);
    // quiet state after reset
    chk_b("power led", power_led_out, 1'b1);
    chk_b("link led", link_led_out, 1'b1);
    chk_b("error led", error_led_out, 1'b0);
    chk_reg(`REG_STATUS, 32'h00000000);
    u_console.wr(`REG_IRQ_MASK, 32'h0000000f, r);
    chk_w("write resp", {30'h0, r}, {30'h0, `RESP_OKAY});
    chk_reg(`REG_IRQ_MASK, 32'h0000000f);
    chk_reg(8'h1c, 32'h00000000);
    chk_w("unmapped read resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    u_console.wr(8'h1c, 32'h0000000f, r);
    chk_w("unmapped write resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    $display("reset and bus test done");
    // program entry table in program mode
    foreach (rows[i]) begin
      last_loc_nop_in <= rows[i].no_operation_instruction;
      u_console.wr(`REG_ENTRY, {6'h00, rows[i].a, rows[i].o}, r);
      tick(2);
      chk_reg(`REG_ENTRY_RESULT, {28'h0, rows[i].res});
      chk_b("power led", power_led_out, 1'b1);
      chk_b("run led", run_led_out, 1'b0);
    end
    chk_reg(`REG_ENTRY, 32'h015b0fff);
    chk_w("prog port", {6'h0, prog_addr_out, prog_word_out}, 32'h015b0fff);
    chk_b("irq entry", irq_out, 1'b1);
    u_console.wr(`REG_IRQ_MASK, 32'h00000000, r);
    tick(2);
    chk_b("irq masked", irq_out, 1'b0);
    u_console.wr(`REG_IRQ_MASK, 32'h0000000f, r);
    u_console.wr(`REG_IRQ_STATUS, 32'h00000004, r);
    tick(2);
    chk_b("irq cleared", irq_out, 1'b0);
    $display("entry test done");
    // run mode with a link fault: non-fatal, nothing removed
    kick_en <= 1'b1;
    u_console.wr(`REG_CTRL, 32'h00000001, r);
    tick(2);
    chk_b("outputs on", outputs_on_out, 1'b1);
    u_console.wr(`REG_ENTRY, 32'h00010001, r);
    tick(2);
    chk_reg(`REG_ENTRY_RESULT, {28'h0, `ENTRY_REFUSED});
    chk_w("prog writes", n_prog, 1);
    link_fault_in <= 1'b1;
    tick(6);
    chk_b("link led", link_led_out, 1'b0);
    chk_b("outputs on", outputs_on_out, 1'b1);
    u_console.press(1'b1, 1'b1);
    tick(2);
    u_console.show(c);
    chk_w("message", {28'h0, c}, {28'h0, `MSG_LINK_FAULT});
    chk_reg(`REG_STATUS, 32'h00000015);
    u_console.press(1'b1, 1'b1);
    link_fault_in <= 1'b0;
    u_console.press(1'b1, 1'b0);
    tick(4);
    chk_b("link led", link_led_out, 1'b1);
    chk_reg(`REG_STATUS, 32'h00000011);
    $display("link fault test done");
    // watchdog expiry then a memory fault
    kick_en <= 1'b0;
    tick(30);
    chk_b("error led", error_led_out, 1'b1);
    chk_b("outputs on", outputs_on_out, 1'b0);
    chk_b("run led", run_led_out, 1'b0);
    mem_fault_in <= 1'b1;
    tick(1);
    mem_fault_in <= 1'b0;
    tick(2);
    chk_reg(`REG_STATUS, 32'h00000032);
    // read out in program mode, oldest first
    foreach (seq[i]) begin
      u_console.press(1'b0, 1'b1);
      tick(2);
      u_console.show(c);
      chk_w("message", {28'h0, c}, {28'h0, seq[i]});
      if (c == `MSG_LINK_FAULT) u_console.press(1'b0, 1'b0);
    end
    tick(2);
    chk_b("error led", error_led_out, 1'b0);
    chk_reg(`REG_STATUS, 32'h00000000);
    $display("fatal test done");
    // run request without an end instruction
    end_found_in <= 1'b0;
    u_console.wr(`REG_CTRL, 32'h00000001, r);
    tick(2);
    chk_b("run led", run_led_out, 1'b0);
    chk_reg(`REG_STATUS, 32'h00000012);
    end_found_in <= 1'b1;
    u_console.press(1'b0, 1'b1);
    u_console.show(c);
    chk_w("message", {28'h0, c}, {28'h0, `MSG_MISSING_TERM});
    tick(3);
    chk_b("error led", error_led_out, 1'b0);
    $display("terminator test done");
    // power fault and a second reset
    power_fault_in <= 1'b1;
    tick(5);
    chk_b("power led", power_led_out, 1'b0);
    chk_b("error led", error_led_out, 1'b0);
    power_fault_in <= 1'b0;
    kick_en <= 1'b1;
    tick(5);
    u_console.wr(`REG_CTRL, 32'h00000001, r);
    tick(2);
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(4);
    chk_b("run led", run_led_out, 1'b0);
    chk_reg(`REG_STATUS, 32'h00000000);
    $display("power and reset test done");
    conclude();
  end
endmodule : controller_fault_reporting_bench

// ---- fault_defs.svh ----
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

// clock and watchdog timing
`define CLK_MHZ 250
`define WDOG_TIME_MS 100

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MESSAGE 8'h08
`define REG_ENTRY 8'h0c
`define REG_ENTRY_RESULT 8'h10
`define REG_IRQ_STATUS 8'h14
`define REG_IRQ_MASK 8'h18

// control register bits
`define CTRL_RUN 0
`define CTRL_CLEAR_KEY 1
`define CTRL_MONITOR_KEY 2

// entry register fields
`define ENTRY_OPND_LSB 0
`define ENTRY_OPND_MSB 15
`define ENTRY_ADDR_LSB 16
`define ENTRY_ADDR_MSB 25

// program memory and operand limits
`define PROG_LAST_ADDR 10'h15b
`define OPERAND_MAX 16'h0fff

// message codes
`define MSG_NONE 4'h0
`define MSG_ALL_CLEAR 4'h1
`define MSG_MEMORY 4'h2
`define MSG_WATCHDOG 4'h3
`define MSG_MISSING_TERM 4'h4
`define MSG_LINK_FAULT 4'h5

// entry result codes
`define ENTRY_OK 4'h0
`define ENTRY_PROG_OVER 4'h1
`define ENTRY_ADDR_OVER 4'h2
`define ENTRY_OPND_ERR 4'h3
`define ENTRY_REFUSED 4'h4

// interrupt status bits
`define IRQ_FATAL 0
`define IRQ_LINK 1
`define IRQ_ENTRY_ERR 2
`define IRQ_MSG 3
`define IRQ_BITS 4

// message store
`define MSG_DEPTH 8
`define MSG_PTR_W 3
`define MSG_CNT_W 4

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- fault_pkg.sv ----
`include "fault_defs.svh"

package fault_pkg;

  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef logic [3:0] code_t;

  // operating mode, one-hot
  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b01,
    MODE_RUN = 2'b10
  } mode_t;

  // whole state of the fault unit
  typedef struct packed {
    logic pwr_s1;
    logic pwr_s2;
    logic link_s1;
    logic link_s2;
    logic link_s3;
    logic awready;
    logic wready;
    logic arready;
    logic aw_full;
    logic w_full;
    addr_t aw_addr;
    word_t w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    word_t rdata;
    logic [1:0] rresp;
    mode_t mode;
    logic fatal;
    logic link_fault;
    logic [31:0] wdog_cnt;
    logic [`MSG_DEPTH-1:0][3:0] mem;
    logic [`MSG_PTR_W-1:0] rd_ptr;
    logic [`MSG_PTR_W-1:0] wr_ptr;
    logic [`MSG_PTR_W-1:0] peek;
    logic [`MSG_CNT_W-1:0] count;
    code_t message;
    code_t entry_result;
    logic [`IRQ_BITS-1:0] irq_stat;
    logic [`IRQ_BITS-1:0] irq_mask;
    logic irq;
    logic outputs_on;
    logic power_led;
    logic run_led;
    logic error_led;
    logic link_led;
    logic prog_wr;
    logic [9:0] prog_addr;
    logic [15:0] prog_word;
  } state_t;

endpackage : fault_pkg
